// ===== verilog/dcb_bank.v
/*
 file: drive calibration object bank, reached by index and subindex
 from the fieldbus protocol engine, plus supervision outputs.
 assumes: the protocol engine delivers one-cycle access strobes on
 mclk_i; measured bus voltage arrives from the converter logic on
 the same clock; the network-loss input is a pin.
*/
// How it works
// - idle current limit, rw 16 bit, 1250
// - zero limit disables rotor field cancellation
// - record subindex zero reads count 11
// - stator current range rw 32, 24229
// - min bus voltage 12000; below it gain max
// - rated bus voltage rw 32, 24000
// - above maximum bus voltage switch ballast on
// - ballast voltage 4000, full-on excess above max
// - brake rated voltage 24000 for brake output
// - stator inductance rw 32, 400 microhenry
// - position gains scaled by reciprocal gain 22563
// - ramp overrun cancels, flags error, code 6343
// - ramp limit clamped to its upper bound
// - network loss acts on stored action code
// - error code mirrors low half, resets zero
`timescale 1ns/1ns
`include "dcb_regs.vh"

module dcb_bank #(
  parameter W = 32
) (
  input wire mclk_i,
  input wire rst_b_i,
  input wire acc_wr_i,
  input wire acc_rd_i,
  input wire [15:0] acc_idx_i,
  input wire [7:0] acc_sub_i,
  input wire [W-1:0] acc_wdata_i,
  input wire [W-1:0] bus_voltage_i,
  input wire loop_tick_i,
  input wire ramp_active_i,
  input wire [31:0] err_history_i,
  input wire err_history_vld_i,
  input wire net_lost_pin_i,
  output reg acc_ack_o,
  output reg acc_err_o,
  output reg [W-1:0] acc_rdata_o,
  output reg field_cancel_en_o,
  output reg gain_at_max_o,
  output reg ballast_on_o,
  output reg [7:0] ballast_level_o,
  output reg [W-1:0] brake_voltage_o,
  output reg [W-1:0] current_range_o,
  output reg [W-1:0] inductance_o,
  output reg [W-1:0] position_gain_reciprocal_o,
  output reg [15:0] idle_limit_o,
  output reg ramp_cancel_o,
  output reg emcy_vld_o,
  output reg [15:0] emcy_code_o,
  output reg [15:0] command_word_o,
  output reg loss_fault_o,
  output reg loss_disable_o,
  output reg loss_qstop_o
);
  //////////////////////////////////////////////////////////////////////
  // storage
  reg [15:0] idle_limit_r;
  reg [W-1:0] cur_range_r;
  reg [W-1:0] vmin_r;
  reg [W-1:0] vrated_r;
  reg [W-1:0] vmax_r;
  reg [W-1:0] vbrake_r;
  reg [W-1:0] vballast_r;
  reg [W-1:0] ind_r;
  reg [W-1:0] gain_r;
  reg [W-1:0] ramp_r;
  reg [15:0] loss_r;
  reg [15:0] err_r;
  reg [15:0] cmd_r;
  reg net_lost_d_r;
  wire net_lost_s;
  wire ramp_over;
  wire is_cal;
  wire [W-1:0] ramp_clamped;
  wire [W-1:0] over_v;
  wire [W-1:0] ballast_top;
  wire [W+7:0] ballast_scaled;
  reg hit;
  reg ro_hit;
  reg [W-1:0] rd_nxt;

  assign is_cal = (acc_idx_i == `DCB_IDX_CAL);
  // clamp in hardware so an out-of-range write cannot stretch the limit
  assign ramp_clamped = (acc_wdata_i > `DCB_RAMP_MAX) ?
    `DCB_RAMP_MAX : acc_wdata_i;

  //////////////////////////////////////////////////////////////////////
  // pin synchroniser and ramp timer
  dcb_sync #(
    .W(1)
  ) u_sync (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .d_i(net_lost_pin_i),
    .q_o(net_lost_s)
  );

  dcb_ramp_timer #(
    .W(W)
  ) u_ramp (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .active_i(ramp_active_i),
    .tick_i(loop_tick_i),
    .limit_i(ramp_r),
    .over_o(ramp_over)
  );

  //////////////////////////////////////////////////////////////////////
  // address decode and read mux
  always @* begin
    hit = 1'b1;
    ro_hit = 1'b0;
    rd_nxt = {W{1'b0}};
    if (is_cal) begin
      case (acc_sub_i)
        `DCB_SUB_COUNT: begin
          rd_nxt = {{(W-8){1'b0}}, `DCB_RST_COUNT};
          ro_hit = 1'b1;
        end
        `DCB_SUB_CUR: rd_nxt = cur_range_r;
        `DCB_SUB_VMIN: rd_nxt = vmin_r;
        `DCB_SUB_VRATED: rd_nxt = vrated_r;
        `DCB_SUB_VMAX: rd_nxt = vmax_r;
        `DCB_SUB_VBRAKE: rd_nxt = vbrake_r;
        `DCB_SUB_VBALLAST: rd_nxt = vballast_r;
        `DCB_SUB_IND: rd_nxt = ind_r;
        `DCB_SUB_GAIN: rd_nxt = gain_r;
        `DCB_SUB_RAMP: rd_nxt = ramp_r;
        default: hit = 1'b0;
      endcase
    end else if (acc_sub_i != `DCB_SUB_ZERO) begin
      hit = 1'b0;
    end else begin
      case (acc_idx_i)
        `DCB_IDX_IDLE: rd_nxt = {{(W-16){1'b0}}, idle_limit_r};
        `DCB_IDX_LOSS: rd_nxt = {{(W-16){1'b0}}, loss_r};
        `DCB_IDX_ERR: begin
          rd_nxt = {{(W-16){1'b0}}, err_r};
          ro_hit = 1'b1;
        end
        `DCB_IDX_CMD: rd_nxt = {{(W-16){1'b0}}, cmd_r};
        default: hit = 1'b0;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // access answer: one cycle after the strobe
  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      acc_ack_o <= 1'b0;
      acc_err_o <= 1'b0;
      acc_rdata_o <= {W{1'b0}};
    end else begin
      acc_ack_o <= acc_wr_i | acc_rd_i;
      acc_err_o <= (acc_wr_i & (~hit | ro_hit)) |
        (acc_rd_i & ~hit);
      if (acc_rd_i) begin
        acc_rdata_o <= rd_nxt;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // writable entries; read-only ones take no write
  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      idle_limit_r <= `DCB_RST_IDLE;
      cur_range_r <= `DCB_RST_CUR;
      vmin_r <= `DCB_RST_VMIN;
      vrated_r <= `DCB_RST_VRATED;
      vmax_r <= `DCB_RST_VMAX;
      vbrake_r <= `DCB_RST_VBRAKE;
      vballast_r <= `DCB_RST_VBALLAST;
      ind_r <= `DCB_RST_IND;
      gain_r <= `DCB_RST_GAIN;
      ramp_r <= `DCB_RST_RAMP;
      loss_r <= `DCB_RST_LOSS;
      cmd_r <= `DCB_RST_CMD;
    end else if (acc_wr_i && hit && !ro_hit) begin
      if (is_cal) begin
        case (acc_sub_i)
          `DCB_SUB_CUR: cur_range_r <= acc_wdata_i;
          `DCB_SUB_VMIN: vmin_r <= acc_wdata_i;
          `DCB_SUB_VRATED: vrated_r <= acc_wdata_i;
          `DCB_SUB_VMAX: vmax_r <= acc_wdata_i;
          `DCB_SUB_VBRAKE: vbrake_r <= acc_wdata_i;
          `DCB_SUB_VBALLAST: vballast_r <= acc_wdata_i;
          `DCB_SUB_IND: ind_r <= acc_wdata_i;
          `DCB_SUB_GAIN: gain_r <= acc_wdata_i;
          `DCB_SUB_RAMP: ramp_r <= ramp_clamped;
          default: ramp_r <= ramp_r;
        endcase
      end else begin
        case (acc_idx_i)
          `DCB_IDX_IDLE: idle_limit_r <= acc_wdata_i[15:0];
          `DCB_IDX_LOSS: loss_r <= acc_wdata_i[15:0];
          `DCB_IDX_CMD: cmd_r <= acc_wdata_i[15:0];
          default: cmd_r <= cmd_r;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // error code: follows the history, a ramp overrun wins the cycle
  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      err_r <= `DCB_RST_ERR;
    end else if (ramp_over) begin
      err_r <= `DCB_EMCY_RAMP;
    end else if (err_history_vld_i) begin
      err_r <= err_history_i[15:0];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // supervision of bus voltage and ballast drive
  assign over_v = bus_voltage_i - vmax_r;
  // a zero ballast span means full drive on any excess
  assign ballast_top = (vballast_r == {W{1'b0}}) ?
    {{(W-1){1'b0}}, 1'b1} : vballast_r;
  // widened so a large ballast span cannot overflow the product
  assign ballast_scaled = ({8'h00, over_v} *
    {{W{1'b0}}, `DCB_BALLAST_FULL}) / {8'h00, ballast_top};

  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      gain_at_max_o <= 1'b0;
      ballast_on_o <= 1'b0;
      ballast_level_o <= 8'h00;
      field_cancel_en_o <= 1'b1;
    end else begin
      gain_at_max_o <= (bus_voltage_i < vmin_r);
      ballast_on_o <= (bus_voltage_i > vmax_r);
      field_cancel_en_o <= (idle_limit_r != 16'h0000);
      if (bus_voltage_i <= vmax_r) begin
        ballast_level_o <= 8'h00;
      end else if (over_v >= ballast_top) begin
        ballast_level_o <= `DCB_BALLAST_FULL;
      end else begin
        // linear ramp; the divide is slow but keeps the code small
        ballast_level_o <= ballast_scaled[7:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // parameter outputs to the control loops
  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      brake_voltage_o <= `DCB_RST_VBRAKE;
      current_range_o <= `DCB_RST_CUR;
      inductance_o <= `DCB_RST_IND;
      position_gain_reciprocal_o <= `DCB_RST_GAIN;
      idle_limit_o <= `DCB_RST_IDLE;
      command_word_o <= `DCB_RST_CMD;
    end else begin
      brake_voltage_o <= vbrake_r;
      current_range_o <= cur_range_r;
      inductance_o <= ind_r;
      position_gain_reciprocal_o <= gain_r;
      idle_limit_o <= idle_limit_r;
      command_word_o <= cmd_r;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // ramp overrun and network-loss reaction
  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      ramp_cancel_o <= 1'b0;
      emcy_vld_o <= 1'b0;
      emcy_code_o <= 16'h0000;
      net_lost_d_r <= 1'b0;
      loss_fault_o <= 1'b0;
      loss_disable_o <= 1'b0;
      loss_qstop_o <= 1'b0;
    end else begin
      ramp_cancel_o <= ramp_over;
      emcy_vld_o <= ramp_over;
      if (ramp_over) begin
        emcy_code_o <= `DCB_EMCY_RAMP;
      end
      net_lost_d_r <= net_lost_s;
      // one pulse on the loss edge, chosen by the stored code
      loss_fault_o <= net_lost_s & ~net_lost_d_r &
        (loss_r == `DCB_LOSS_FAULT);
      loss_disable_o <= net_lost_s & ~net_lost_d_r &
        (loss_r == `DCB_LOSS_DISV);
      loss_qstop_o <= net_lost_s & ~net_lost_d_r &
        (loss_r == `DCB_LOSS_QSTOP);
    end
  end
endmodule // dcb_bank

// ===== shared/dcb_regs.vh
/*
 file: object indices, subindices, defaults and codes of the
 calibration object bank.
 assumes: included by bare name from the design files.
*/
`ifndef DCB_REGS_VH
`define DCB_REGS_VH

// object indices
`define DCB_IDX_CAL 16'h2f04
`define DCB_IDX_LOSS 16'h6007
`define DCB_IDX_ERR 16'h603f
`define DCB_IDX_CMD 16'h6040
`define DCB_IDX_IDLE 16'h2f05

// subindices of the calibration record
`define DCB_SUB_COUNT 8'h00
`define DCB_SUB_CUR 8'h01
`define DCB_SUB_VMIN 8'h02
`define DCB_SUB_VRATED 8'h03
`define DCB_SUB_VMAX 8'h04
`define DCB_SUB_VBRAKE 8'h05
`define DCB_SUB_VBALLAST 8'h06
`define DCB_SUB_IND 8'h07
`define DCB_SUB_GAIN 8'h0a
`define DCB_SUB_RAMP 8'h0b
`define DCB_SUB_ZERO 8'h00

// defaults
`define DCB_RST_COUNT 8'h0b
`define DCB_RST_CUR 32'h00005ea5
`define DCB_RST_VMIN 32'h00002ee0
`define DCB_RST_VRATED 32'h00005dc0
`define DCB_RST_VMAX 32'h00007530
`define DCB_RST_VBRAKE 32'h00005dc0
`define DCB_RST_VBALLAST 32'h00000fa0
`define DCB_RST_IND 32'h00000190
`define DCB_RST_GAIN 32'h00005823
`define DCB_RST_RAMP 32'h02255100
`define DCB_RST_LOSS 16'h0001
`define DCB_RST_ERR 16'h0000
`define DCB_RST_CMD 16'h0000
`define DCB_RST_IDLE 16'h04e2

// upper bound of the ramp limit, in current-loop cycles
`define DCB_RAMP_MAX 32'hfffd7280

// emergency code for ramp overrun
`define DCB_EMCY_RAMP 16'h6343

// connection-loss actions
`define DCB_LOSS_NONE 16'h0000
`define DCB_LOSS_FAULT 16'h0001
`define DCB_LOSS_DISV 16'h0002
`define DCB_LOSS_QSTOP 16'h0003

// full ballast drive
`define DCB_BALLAST_FULL 8'hff

`endif

// ===== verilog/dcb_ramp_timer.v
/*
 file: ramp duration supervision counter.
 assumes: tick_i is one pulse per current-loop cycle on mclk_i.
*/
`timescale 1ns/1ns
`include "dcb_regs.vh"

module dcb_ramp_timer #(
  parameter W = 32
) (
  input wire mclk_i,
  input wire rst_b_i,
  input wire active_i,
  input wire tick_i,
  input wire [W-1:0] limit_i,
  output reg over_o
);
  reg [W-1:0] cnt_r;

  // counts while a move runs; flags one pulse when the limit is passed
  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      cnt_r <= {W{1'b0}};
      over_o <= 1'b0;
    end else begin
      over_o <= 1'b0;
      if (!active_i) begin
        cnt_r <= {W{1'b0}};
      end else if (tick_i) begin
        if (cnt_r >= limit_i) begin
          over_o <= 1'b1;
          cnt_r <= {W{1'b0}};
        end else begin
          cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // dcb_ramp_timer

// ===== verilog/dcb_sync.v
/*
 file: three-stage synchroniser for a bus of pin inputs.
 assumes: inputs come from outside the mclk_i domain.
*/
`timescale 1ns/1ns

module dcb_sync #(
  parameter W = 1
) (
  input wire mclk_i,
  input wire rst_b_i,
  input wire [W-1:0] d_i,
  output reg [W-1:0] q_o
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;

  // output follows only once stages two and three agree
  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
      s3_r <= {W{1'b0}};
      q_o <= {W{1'b0}};
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        q_o <= s3_r;
      end
    end
  end
endmodule // dcb_sync

// ===== tb/dcb_bank_sva.sv
/*
 dcb_bank_chk: port checker for the calibration object bank.
 assumes: bound into dcb_bank; one clock, sync reset active low.
*/
`timescale 1ns/1ns
module dcb_bank_chk #(
  parameter W = 32
) (
  input wire mclk_i,
  input wire rst_b_i,
  input wire acc_wr_i,
  input wire acc_rd_i,
  input wire [15:0] acc_idx_i,
  input wire [7:0] acc_sub_i,
  input wire ramp_active_i,
  input wire acc_ack_o,
  input wire acc_err_o,
  input wire field_cancel_en_o,
  input wire [15:0] idle_limit_o,
  input wire ramp_cancel_o,
  input wire emcy_vld_o,
  input wire [15:0] emcy_code_o,
  input wire loss_fault_o,
  input wire loss_disable_o,
  input wire loss_qstop_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  // one strobe is one access; read-only targets get their own shape
  sequence s_req;
    acc_wr_i || acc_rd_i;
  endsequence
  sequence s_ro_wr;
    acc_wr_i && (acc_idx_i == 16'h603f ||
      (acc_idx_i == 16'h2f04 && acc_sub_i == 8'h00));
  endsequence
  ////////////////////////////////////////////////////////////
  a_ack_on_req: assert property (s_req |=> acc_ack_o)
    else $error("no answer one cycle after a strobe");
  a_err_with_ack: assert property (acc_err_o |-> acc_ack_o)
    else $error("reject flag without answer");
  a_ro_write_rej: assert property (s_ro_wr |=> acc_err_o)
    else $error("write to read-only entry accepted");
  a_unmapped_rej: assert property (acc_rd_i && acc_idx_i == 16'h0000
    |=> acc_err_o)
    else $error("unmapped read accepted");
  // the [*3] lets the limit copy and the enable settle
  a_cancel_off: assert property ((idle_limit_o == 16'h0000)[*3]
    |-> !field_cancel_en_o)
    else $error("field cancellation on with zero limit");
  a_cancel_on: assert property ((idle_limit_o != 16'h0000)[*3]
    |-> field_cancel_en_o)
    else $error("field cancellation off with nonzero limit");
  a_emcy_code_val: assert property (emcy_vld_o |=>
    emcy_code_o == 16'h6343)
    else $error("wrong emergency code");
  a_abort_emcy: assert property (ramp_cancel_o |-> emcy_vld_o)
    else $error("ramp cancel without emergency");
  a_abort_cause: assert property (ramp_cancel_o |->
    $past(ramp_active_i, 2))
    else $error("ramp cancel with no move running");
  a_loss_onehot: assert property ($onehot0({loss_fault_o,
    loss_disable_o, loss_qstop_o}))
    else $error("two loss reactions at once");
  a_loss_single: assert property (loss_fault_o |=> !loss_fault_o)
    else $error("fault reaction longer than one pulse");
endmodule // dcb_bank_chk

bind dcb_bank dcb_bank_chk #(.W(W)) chk_u (.*);

// ===== tb/dcb_master.sv
/*
 dcb_master: fieldbus master model on the bank's access port.
 assumes: one-cycle strobes, answer within a few cycles.
*/
`timescale 1ns/1ns
module dcb_master (
  input wire mclk_i,
  input wire acc_ack_i,
  input wire acc_err_i,
  input wire [31:0] acc_rdata_i,
  output logic acc_wr_o,
  output logic acc_rd_o,
  output logic [15:0] acc_idx_o,
  output logic [7:0] acc_sub_o,
  output logic [31:0] acc_wdata_o
);
  ////////////////////////////////////////////////////////////
  // idle port at time zero
  initial begin
    acc_wr_o = 1'b0;
    acc_rd_o = 1'b0;
    acc_idx_o = 16'h0000;
    acc_sub_o = 8'h00;
    acc_wdata_o = 32'h0;
  end
  // each call is one single access, a write when w is set and a read otherwise
  task automatic xfer(input logic w, input logic [15:0] i,
    input logic [7:0] s, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge mclk_i);
    acc_wr_o <= w;
    acc_rd_o <= !w;
    acc_idx_o <= i;
    acc_sub_o <= s;
    acc_wdata_o <= d;
    @(posedge mclk_i);
    acc_wr_o <= 1'b0;
    acc_rd_o <= 1'b0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (acc_ack_i !== 1'b1 && n < 4);
    q = (n < 4) ? acc_rdata_i : 32'hx;
    e = (n < 4) ? acc_err_i : 1'bx;
    // released index and data lines show junk, never the last value; the subindex keeps it
    acc_idx_o <= ~i;
    acc_wdata_o <= ~d;
  endtask
endmodule // dcb_master

// ===== tb/testbench.sv
/*
 testbench: self-checking bench for dcb_bank.
 assumes: dcb_master drives the access port; 40 ns clock.
*/
`timescale 1ns/1ns
module testbench;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic wr, rd, ack, aerr, tick = 0, ramp = 0, hvld = 0, lost = 0, e;
  logic [15:0] idx;
  logic [7:0] sub;
  logic [31:0] wd, rdat, vbus = 0, hist = 0, q;
  wire fce, gmax, bon, rcan, evld, lf, ld, lq;
  wire [7:0] blev;
  wire [31:0] brk, cur, ind, pgr;
  wire [15:0] idl, ecode, cmd;
  logic [1:0] pf, pd, pq;
  int mismatches = 0, check_count = 0, cyc = 0;
  logic [56:0] rows [0:15] = '{{16'h2f04, 8'h00, 32'hb, 1'b0},
    {16'h2f04, 8'h01, 32'h5ea5, 1'b0}, {16'h2f04, 8'h02, 32'h2ee0, 1'b0},
    {16'h2f04, 8'h03, 32'h5dc0, 1'b0}, {16'h2f04, 8'h04, 32'h7530, 1'b0},
    {16'h2f04, 8'h05, 32'h5dc0, 1'b0}, {16'h2f04, 8'h06, 32'hfa0, 1'b0},
    {16'h2f04, 8'h07, 32'h190, 1'b0}, {16'h2f04, 8'h0a, 32'h5823, 1'b0},
    {16'h2f04, 8'h0b, 32'h2255100, 1'b0}, {16'h6007, 8'h0, 32'h1, 1'b0},
    {16'h603f, 8'h0, 32'h0, 1'b0}, {16'h6040, 8'h0, 32'h0, 1'b0},
    {16'h2f05, 8'h0, 32'h4e2, 1'b0}, {16'h2f04, 8'h08, 32'h0, 1'b1},
    {16'h0000, 8'h0, 32'h0, 1'b1}};
  logic [41:0] vt [0:4] = '{{32'h1000, 10'h200}, {32'h2ee0, 10'h000},
    {32'h7530, 10'h000}, {32'h7d00, 10'h17f}, {32'h84d0, 10'h1ff}};

  dcb_master master_u (.mclk_i(mclk_i), .acc_ack_i(ack), .acc_err_i(aerr),
    .acc_rdata_i(rdat), .acc_wr_o(wr), .acc_rd_o(rd), .acc_idx_o(idx),
    .acc_sub_o(sub), .acc_wdata_o(wd));
  dcb_bank #(.W(32)) dut_u (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .acc_wr_i(wr), .acc_rd_i(rd), .acc_idx_i(idx), .acc_sub_i(sub),
    .acc_wdata_i(wd), .bus_voltage_i(vbus), .loop_tick_i(tick),
    .ramp_active_i(ramp), .err_history_i(hist), .err_history_vld_i(hvld),
    .net_lost_pin_i(lost), .acc_ack_o(ack), .acc_err_o(aerr),
    .acc_rdata_o(rdat), .field_cancel_en_o(fce), .gain_at_max_o(gmax),
    .ballast_on_o(bon), .ballast_level_o(blev), .brake_voltage_o(brk),
    .current_range_o(cur), .inductance_o(ind),
    .position_gain_reciprocal_o(pgr), .idle_limit_o(idl),
    .ramp_cancel_o(rcan), .emcy_vld_o(evld), .emcy_code_o(ecode),
    .command_word_o(cmd), .loss_fault_o(lf), .loss_disable_o(ld),
    .loss_qstop_o(lq));
  ////////////////////////////////////////////////////////////
  // clock, and a cycle ceiling well above the expected run
  always #20 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 6000) begin
      mismatches++;
      close_out;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // settle to the falling edge so outputs are never read mid-update
  task acc(input logic w, input logic [15:0] i, input logic [7:0] s,
    input logic [31:0] d);
    master_u.xfer(w, i, s, d, q, e);
    @(negedge mclk_i);
  endtask
  task cnt(input int n);
    repeat (n) begin
      @(negedge mclk_i);
      pf += 2'(lf);
      pd += 2'(ld);
      pq += 2'(lq);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    foreach (rows[k]) begin
      acc(1'b0, rows[k][56:41], rows[k][40:33], 32'h0);
      chk(32'(e), 32'(rows[k][0]));
      if (!rows[k][0]) chk(q, rows[k][32:1]);
    end
    chk({brk[15:0], idl}, 32'h5dc004e2);
    chk(32'(fce), 32'h1);
    foreach (vt[k]) begin
      @(posedge mclk_i);
      vbus <= vt[k][41:10];
      repeat (4) @(negedge mclk_i);
      chk(32'({gmax, bon, blev}), 32'(vt[k][9:0]));
    end
    for (int k = 1; k < 10; k++) begin
      acc(1'b1, rows[k][56:41], rows[k][40:33], 32'h100 + 32'(k));
      acc(1'b0, rows[k][56:41], rows[k][40:33], 32'h0);
      chk(q, 32'h100 + 32'(k));
    end
    chk(cur ^ brk ^ ind ^ pgr, 32'h101 ^ 32'h105 ^ 32'h107 ^ 32'h108);
    acc(1'b1, 16'h2f04, 8'h0b, 32'hffffffff);
    acc(1'b0, 16'h2f04, 8'h0b, 32'h0);
    chk(q, 32'hfffd7280);
    acc(1'b1, 16'h2f04, 8'h00, 32'h55);
    chk(32'(e), 32'h1);
    acc(1'b1, 16'h603f, 8'h00, 32'h55);
    chk(32'(e), 32'h1);
    acc(1'b0, 16'h2f04, 8'h00, 32'h0);
    chk(q, 32'hb);
    acc(1'b0, 16'h603f, 8'h00, 32'h0);
    chk(q, 32'h0);
    acc(1'b1, 16'h2f05, 8'h00, 32'h0);
    repeat (3) @(negedge mclk_i);
    chk(32'(fce), 32'h0);
    acc(1'b1, 16'h2f05, 8'h00, 32'h4e2);
    repeat (3) @(negedge mclk_i);
    chk(32'(fce), 32'h1);
    acc(1'b1, 16'h6040, 8'h00, 32'hffff000f);
    chk(32'(cmd), 32'hf);
    // error history takes the low half only
    @(posedge mclk_i);
    hist <= 32'h1234abcd;
    hvld <= 1'b1;
    @(posedge mclk_i);
    hvld <= 1'b0;
    acc(1'b0, 16'h603f, 8'h00, 32'h0);
    chk(q, 32'habcd);
    // a short ramp limit so the overrun comes quickly
    acc(1'b1, 16'h2f04, 8'h0b, 32'h5);
    @(posedge mclk_i);
    ramp <= 1'b1;
    tick <= 1'b1;
    for (int n = 0; n < 40 && rcan !== 1'b1; n++) @(negedge mclk_i);
    chk(32'({rcan, evld}), 32'h3);
    @(posedge mclk_i);
    ramp <= 1'b0;
    tick <= 1'b0;
    acc(1'b0, 16'h603f, 8'h00, 32'h0);
    chk({ecode, q[15:0]}, 32'h63436343);
    for (int c = 0; c < 4; c++) begin
      acc(1'b1, 16'h6007, 8'h00, 32'(c));
      pf = 0;
      pd = 0;
      pq = 0;
      @(posedge mclk_i);
      lost <= 1'b1;
      cnt(14);
      @(posedge mclk_i);
      lost <= 1'b0;
      cnt(12);
      chk(32'({pf, pd, pq}), (c == 0) ? 0 : 32'h1 << (2 * (3 - c)));
    end
    @(posedge mclk_i);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    acc(1'b0, 16'h6040, 8'h00, 32'h0);
    chk(q, 32'h0);
    close_out;
  end
endmodule // testbench
